//--- exc_pkg.sv
// Constants and types shared by the exception priority and vectoring block.
package exc_pkg;

  // ==========================================================================
  // Fixed addresses and reset values
  // ==========================================================================
  // The reset vector lives at one fixed address and no table base moves it.
  localparam logic [31:0] RESET_VECTOR_ADDR = 32'hFFFF_FFFC;
  localparam logic RESET_IE = 1'b1;
  localparam logic [3:0] RESET_MASK = 4'h0;
  // A fast interrupt ranks as the top maskable level.
  localparam logic [3:0] FAST_LEVEL = 4'hF;
  // Table entries are one 32-bit word, so the vector number is scaled by four.
  localparam logic [1:0] VEC_ZERO_LSB = 2'h0;
  localparam logic [21:0] VEC_ZERO_MSB = 22'h0;

  // ==========================================================================
  // Entry numbers in the exception table
  // ==========================================================================
  localparam logic [7:0] XV_PRIV = 8'h14;
  localparam logic [7:0] XV_IACC = 8'h15;
  localparam logic [7:0] XV_UNDEF = 8'h17;
  localparam logic [7:0] XV_FPU = 8'h19;
  localparam logic [7:0] XV_NMI = 8'h1E;
  localparam logic [7:0] XV_OACC = 8'h1F;

  // ==========================================================================
  // Event ranks and control states
  // ==========================================================================
  localparam int NUM_EVENTS = 8;
  typedef enum logic [2:0] {
    EV_RESET = 3'b000,
    EV_NMI = 3'b001,
    EV_IRQ = 3'b010,
    EV_IACC = 3'b011,
    EV_UNDEF = 3'b100,
    EV_TRAP = 3'b101,
    EV_OACC = 3'b110,
    EV_FPU = 3'b111
  } ev_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01
  } state_t;

endpackage

//--- prio_pick.sv
// Fixed-priority picker: the lowest set request index wins.
`timescale 1ns/1ns
module prio_pick #(
  parameter int N = 8,
  parameter int W = 3
) (
  input wire logic [N-1:0] req,
  output logic any,
  output logic [W-1:0] idx
);

  // ==========================================================================
  // Scan from the bottom rank up, so the last hit is the lowest index.
  // ==========================================================================
  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = W'(i);
      end
    end
  end

endmodule

//--- exc_vectoring.sv
// Exception ranking, interrupt masking and vector fetch control for the CPU core.
//
// Functional notes
// - Rank: reset, NMI, maskable irq, fetch fault, undef/priv, trap, operand fault, FPU.
// - A pending accepted maskable interrupt beats both fetch and operand access faults.
// - Order among maskable sources is the interrupt controller's, not ranked here.
// - Traps and non-fast maskable interrupts read their vector from the table at irq_table_base.
// - System exceptions read their vector from the table at exc_table_base.
// - The reset vector is read from a fixed address that no table base moves.
// - A fast interrupt branches to fast_vector_addr with no table read.
// - A four-bit mask accepts a maskable request only when its level is strictly above the mask.
// - The global enable bit at 0 blocks maskable acceptance, at 1 leaves it to the mask.
// - System reset sets the global enable bit to 1.
// - Accepting any exception other than reset clears the global enable bit until software sets it again.
// - A fast interrupt is a maskable interrupt fixed at level 15 with its own vector path.
`timescale 1ns/1ns
module exc_vectoring (
  input wire logic clk,
  input wire logic rst_b,
  // Request from the interrupt controller.
  input wire logic irq_req,
  input wire logic [3:0] irq_level,
  input wire logic [7:0] irq_vector,
  input wire logic irq_fast,
  input wire logic nmi_req,
  // Exception signals from the pipeline.
  input wire logic exc_insn_access,
  input wire logic exc_undef,
  input wire logic exc_priv,
  input wire logic trap_req,
  input wire logic [7:0] trap_vector,
  input wire logic exc_operand_access,
  input wire logic exc_fpu,
  // Control register values and software writes to the status word fields.
  input wire logic [31:0] irq_table_base,
  input wire logic [31:0] exc_table_base,
  input wire logic [31:0] fast_vector_addr,
  input wire logic ie_wr,
  input wire logic ie_wdata,
  input wire logic mask_wr,
  input wire logic [3:0] mask_wdata,
  // Vector table read port.
  output logic vec_fetch_req,
  output logic [31:0] vec_fetch_addr,
  input wire logic vec_fetch_done,
  input wire logic [31:0] vec_fetch_data,
  // Results.
  output logic exc_taken,
  output logic [2:0] taken_event,
  output logic irq_ack,
  output logic fast_taken,
  output logic handler_valid,
  output logic [31:0] handler_addr,
  output logic int_enable,
  output logic [3:0] cpu_priority_mask
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    exc_pkg::state_t state;
    logic reset_pend;
    logic ie;
    logic [3:0] mask;
    logic fetch_req;
    logic [31:0] fetch_addr;
    logic handler_valid;
    logic [31:0] handler_addr;
    logic taken;
    exc_pkg::ev_t event_q;
    logic irq_ack;
    logic fast;
  } st_t;

  st_t st_r;
  st_t st_nxt;

  logic [3:0] eff_level;
  logic irq_ok;
  logic [exc_pkg::NUM_EVENTS-1:0] ev_req;
  logic ev_any;
  logic [2:0] ev_idx;
  exc_pkg::ev_t ev_pick;

  // ==========================================================================
  // Request gating and ranking
  // ==========================================================================
  // A fast request always compares as the top level, whatever level rides with it.
  assign eff_level = irq_fast ? exc_pkg::FAST_LEVEL : irq_level;
  // Enable bit and strict comparison against the mask decide maskable acceptance.
  assign irq_ok = irq_req && st_r.ie && (eff_level > st_r.mask);

  // Bit position is rank: lower index is the more urgent event.
  assign ev_req[0] = st_r.reset_pend;
  assign ev_req[1] = nmi_req;
  assign ev_req[2] = irq_ok;
  assign ev_req[3] = exc_insn_access;
  assign ev_req[4] = exc_undef || exc_priv;
  assign ev_req[5] = trap_req;
  assign ev_req[6] = exc_operand_access;
  assign ev_req[7] = exc_fpu;

  prio_pick #(
    .N(exc_pkg::NUM_EVENTS),
    .W(3)
  ) u_rank (
    .req(ev_req),
    .any(ev_any),
    .idx(ev_idx)
  );

  assign ev_pick = exc_pkg::ev_t'(ev_idx);

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  // Only one event is taken per idle cycle; later events wait until the vector
  // read completes, which keeps the table port single-outstanding.
  always_comb begin
    st_nxt = st_r;
    st_nxt.taken = 1'b0;
    st_nxt.handler_valid = 1'b0;
    st_nxt.irq_ack = 1'b0;
    st_nxt.fast = 1'b0;
    if (ie_wr) begin
      st_nxt.ie = ie_wdata;
    end
    if (mask_wr) begin
      st_nxt.mask = mask_wdata;
    end
    unique case (st_r.state)
      exc_pkg::ST_IDLE: begin
        if (ev_any) begin
          st_nxt.taken = 1'b1;
          st_nxt.event_q = ev_pick;
          st_nxt.fetch_req = 1'b1;
          st_nxt.state = exc_pkg::ST_FETCH;
          // Entry for any event but reset clears the enable bit and beats a software write in the same cycle.
          if (ev_pick != exc_pkg::EV_RESET) begin
            st_nxt.ie = 1'b0;
          end
          unique case (ev_pick)
            exc_pkg::EV_RESET: begin
              st_nxt.reset_pend = 1'b0;
              st_nxt.fetch_addr = exc_pkg::RESET_VECTOR_ADDR;
            end
            exc_pkg::EV_NMI: begin
              st_nxt.fetch_addr = exc_table_base
                + {exc_pkg::VEC_ZERO_MSB, exc_pkg::XV_NMI, exc_pkg::VEC_ZERO_LSB};
            end
            exc_pkg::EV_IRQ: begin
              st_nxt.irq_ack = 1'b1;
              if (irq_fast) begin
                // No table read: branch straight to the fast vector register.
                st_nxt.fast = 1'b1;
                st_nxt.fetch_req = 1'b0;
                st_nxt.handler_valid = 1'b1;
                st_nxt.handler_addr = fast_vector_addr;
                st_nxt.state = exc_pkg::ST_IDLE;
              end else begin
                st_nxt.fetch_addr = irq_table_base
                  + {exc_pkg::VEC_ZERO_MSB, irq_vector, exc_pkg::VEC_ZERO_LSB};
              end
            end
            exc_pkg::EV_IACC: begin
              st_nxt.fetch_addr = exc_table_base
                + {exc_pkg::VEC_ZERO_MSB, exc_pkg::XV_IACC, exc_pkg::VEC_ZERO_LSB};
            end
            exc_pkg::EV_UNDEF: begin
              // Undefined and privileged share a rank; undefined picks first.
              st_nxt.fetch_addr = exc_table_base + {exc_pkg::VEC_ZERO_MSB,
                (exc_undef ? exc_pkg::XV_UNDEF : exc_pkg::XV_PRIV),
                exc_pkg::VEC_ZERO_LSB};
            end
            exc_pkg::EV_TRAP: begin
              st_nxt.fetch_addr = irq_table_base
                + {exc_pkg::VEC_ZERO_MSB, trap_vector, exc_pkg::VEC_ZERO_LSB};
            end
            exc_pkg::EV_OACC: begin
              st_nxt.fetch_addr = exc_table_base
                + {exc_pkg::VEC_ZERO_MSB, exc_pkg::XV_OACC, exc_pkg::VEC_ZERO_LSB};
            end
            exc_pkg::EV_FPU: begin
              st_nxt.fetch_addr = exc_table_base
                + {exc_pkg::VEC_ZERO_MSB, exc_pkg::XV_FPU, exc_pkg::VEC_ZERO_LSB};
            end
          endcase
        end
      end
      exc_pkg::ST_FETCH: begin
        // The read returns a whole 32-bit handler address.
        if (vec_fetch_done) begin
          st_nxt.fetch_req = 1'b0;
          st_nxt.handler_valid = 1'b1;
          st_nxt.handler_addr = vec_fetch_data;
          st_nxt.state = exc_pkg::ST_IDLE;
        end
      end
      default: begin
        st_nxt.fetch_req = 1'b0;
        st_nxt.state = exc_pkg::ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // Reset leaves a reset event pending so the first action is the fixed-vector read.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= '0;
      st_r.state <= exc_pkg::ST_IDLE;
      st_r.reset_pend <= 1'b1;
      st_r.ie <= exc_pkg::RESET_IE;
      st_r.mask <= exc_pkg::RESET_MASK;
      st_r.event_q <= exc_pkg::EV_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs, all straight from the state register
  // ==========================================================================
  assign vec_fetch_req = st_r.fetch_req;
  assign vec_fetch_addr = st_r.fetch_addr;
  assign exc_taken = st_r.taken;
  assign taken_event = st_r.event_q;
  assign irq_ack = st_r.irq_ack;
  assign fast_taken = st_r.fast;
  assign handler_valid = st_r.handler_valid;
  assign handler_addr = st_r.handler_addr;
  assign int_enable = st_r.ie;
  assign cpu_priority_mask = st_r.mask;

  // ==========================================================================
  // Assertions and covers
  // ==========================================================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // The pending reset is served first and from the fixed address.
  AST_RESET_FIXED: assert property (
    st_r.state == exc_pkg::ST_IDLE && st_r.reset_pend
    |=> exc_taken && taken_event == exc_pkg::EV_RESET
        && vec_fetch_req && vec_fetch_addr == exc_pkg::RESET_VECTOR_ADDR)
    else $error("reset vector not taken from fixed address");

  AST_NMI_RANK: assert property (
    st_r.state == exc_pkg::ST_IDLE && !st_r.reset_pend && nmi_req
    |=> exc_taken && taken_event == exc_pkg::EV_NMI && !irq_ack)
    else $error("nmi lost its rank");

  AST_IRQ_OVER_FAULT: assert property (
    st_r.state == exc_pkg::ST_IDLE && !st_r.reset_pend && !nmi_req && irq_ok
    && (exc_insn_access || exc_operand_access)
    |=> taken_event == exc_pkg::EV_IRQ && irq_ack)
    else $error("access fault beat an accepted interrupt");

  AST_MASK_BLOCK: assert property (
    irq_req && !irq_fast && irq_level <= st_r.mask |=> !irq_ack)
    else $error("request at or below mask was accepted");

  AST_IE_BLOCK: assert property (
    !int_enable |=> !irq_ack)
    else $error("interrupt accepted while disabled");

  AST_IE_AFTER_RESET: assert property (
    !$past(rst_b) |-> int_enable && cpu_priority_mask == exc_pkg::RESET_MASK)
    else $error("enable bit not set by reset");

  AST_IE_CLEARED: assert property (
    exc_taken && taken_event != exc_pkg::EV_RESET
    |-> !int_enable ##1 (!int_enable || $past(ie_wr)))
    else $error("enable bit not cleared on entry");

  AST_IRQ_TABLE: assert property (
    exc_taken && taken_event == exc_pkg::EV_IRQ && !fast_taken
    |-> vec_fetch_req && vec_fetch_addr == $past(irq_table_base)
        + {exc_pkg::VEC_ZERO_MSB, $past(irq_vector), exc_pkg::VEC_ZERO_LSB})
    else $error("interrupt vector address wrong");

  AST_NMI_TABLE: assert property (
    exc_taken && taken_event == exc_pkg::EV_NMI
    |-> vec_fetch_addr == $past(exc_table_base)
        + {exc_pkg::VEC_ZERO_MSB, exc_pkg::XV_NMI, exc_pkg::VEC_ZERO_LSB})
    else $error("exception vector address wrong");

  AST_FAST_PATH: assert property (
    fast_taken |-> handler_valid && !vec_fetch_req
                   && handler_addr == $past(fast_vector_addr))
    else $error("fast interrupt did not use its vector register");

  AST_FETCH_RETURN: assert property (
    st_r.state == exc_pkg::ST_FETCH && vec_fetch_done
    |=> handler_valid && handler_addr == $past(vec_fetch_data) && !vec_fetch_req)
    else $error("fetched handler address not delivered");

  COV_FAST: cover property (fast_taken);
  COV_IRQ_FETCH: cover property (irq_ack && vec_fetch_req ##[1:20] handler_valid);
  COV_NMI_OVER_IRQ: cover property (st_r.state == exc_pkg::ST_IDLE && nmi_req && irq_ok);
  COV_TRAP: cover property (exc_taken && taken_event == exc_pkg::EV_TRAP);

endmodule

//--- vec_mem.sv
// Behavioural vector table that answers the block's handler reads.
`timescale 1ns/1ns
module vec_mem #(
  parameter logic [31:0] KEY = 32'h5A5A_0000
) (
  input wire logic clk,
  input wire logic vec_fetch_req,
  input wire logic [31:0] vec_fetch_addr,
  input wire logic [2:0] lag,
  output logic vec_fetch_done,
  output logic [31:0] vec_fetch_data
);
  int cnt = 0;
  // ==========================================================================
  // Read response
  // ==========================================================================
  // The word comes lag cycles after the read shows. Outside the done cycle the
  // data lines carry the inverse of the last word, so a stale value never passes.
  initial begin
    vec_fetch_done = 1'b0;
    vec_fetch_data = 32'h0;
  end
  always @(posedge clk) begin
    #1;
    if (vec_fetch_done) begin
      vec_fetch_done = 1'b0;
      vec_fetch_data = ~vec_fetch_data;
    end else if (vec_fetch_req && cnt >= lag) begin
      vec_fetch_done = 1'b1;
      vec_fetch_data = vec_fetch_addr ^ KEY;
      cnt = 0;
    end else if (vec_fetch_req) begin
      cnt = cnt + 1;
    end
  end
endmodule

//--- exc_vectoring_bench.sv
// Self-checking bench for the exception ranking and vectoring block.
`timescale 1ns/1ns
module exc_vectoring_bench;
  localparam logic [31:0] KEY = 32'h5A5A_0000;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] src = 8'h00;
  logic [3:0] irq_level = 4'h0, mask_wdata = 4'h0, cpu_priority_mask;
  logic [7:0] irq_vector = 8'h00, trap_vector = 8'h00;
  logic [31:0] irq_table_base = 32'h1000_0000, exc_table_base = 32'h2000_0000;
  logic [31:0] fast_vector_addr = 32'h3000_0000, vec_fetch_addr, vec_fetch_data, handler_addr;
  logic irq_fast = 1'b0, ie_wr = 1'b0, ie_wdata = 1'b0, mask_wr = 1'b0;
  logic [2:0] lag = 3'h0, taken_event;
  logic vec_fetch_req, vec_fetch_done, exc_taken, irq_ack, fast_taken, handler_valid, int_enable;
  logic irq_ok;
  logic [31:0] addr;
  int bad_count = 0, checks_done = 0, cycles = 0, seed = 31, ie_m, mask_m, ev, i;

  // Sources: bit 0 nmi, 1 irq, 2 fetch fault, 3 undef, 4 priv, 5 trap, 6 operand, 7 fpu.
  exc_vectoring exc_vectoring_inst (.clk(clk), .rst_b(rst_b), .irq_req(src[1]),
    .irq_level(irq_level), .irq_vector(irq_vector), .irq_fast(irq_fast), .nmi_req(src[0]),
    .exc_insn_access(src[2]), .exc_undef(src[3]), .exc_priv(src[4]), .trap_req(src[5]),
    .trap_vector(trap_vector), .exc_operand_access(src[6]), .exc_fpu(src[7]),
    .irq_table_base(irq_table_base), .exc_table_base(exc_table_base),
    .fast_vector_addr(fast_vector_addr), .ie_wr(ie_wr), .ie_wdata(ie_wdata),
    .mask_wr(mask_wr), .mask_wdata(mask_wdata), .vec_fetch_req(vec_fetch_req),
    .vec_fetch_addr(vec_fetch_addr), .vec_fetch_done(vec_fetch_done),
    .vec_fetch_data(vec_fetch_data), .exc_taken(exc_taken), .taken_event(taken_event),
    .irq_ack(irq_ack), .fast_taken(fast_taken), .handler_valid(handler_valid),
    .handler_addr(handler_addr), .int_enable(int_enable),
    .cpu_priority_mask(cpu_priority_mask));
  vec_mem #(.KEY(KEY)) vec_mem_inst (.clk(clk), .vec_fetch_req(vec_fetch_req),
    .vec_fetch_addr(vec_fetch_addr), .lag(lag), .vec_fetch_done(vec_fetch_done),
    .vec_fetch_data(vec_fetch_data));

  // ==========================================================================
  // Clock, timeout and reporting
  // ==========================================================================
  always #50 clk = ~clk;
  // About 700 cycles are expected; the ceiling leaves a wide margin.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      $display("unexpected timeout after %0d cycles", cycles);
      end_sim();
    end
  end
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_flag(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask
  // Inputs move one nanosecond after each rising edge, where outputs are settled.
  task tick;
    @(posedge clk);
    #1;
  endtask
  function automatic logic [31:0] slot(input logic [31:0] b, input logic [7:0] n);
    return b + {22'h0, n, 2'h0};
  endfunction

  // ==========================================================================
  // Accepted event: wait for it, then follow the vector read to the handler
  // ==========================================================================
  // Requests are levels, so they are dropped as soon as the accept is seen.
  task automatic take(input int e, input logic [31:0] a, input logic f);
    int n;
    n = 0;
    do begin
      tick();
      n++;
    end while (exc_taken !== 1'b1 && n < 12);
    src = 8'h00;
    chk_flag("exc_taken", 1'b1, exc_taken);
    chk_val("taken_event", e, taken_event);
    chk_flag("irq_ack", e == 2, irq_ack);
    chk_flag("fast_taken", f, fast_taken);
    chk_flag("int_enable", e == 0, int_enable);
    chk_flag("vec_fetch_req", !f, vec_fetch_req);
    if (f) begin
      chk_flag("handler_valid", 1'b1, handler_valid);
      chk_val("handler_addr", fast_vector_addr, handler_addr);
    end else begin
      chk_val("vec_fetch_addr", a, vec_fetch_addr);
      n = 0;
      do begin
        tick();
        n++;
      end while (handler_valid !== 1'b1 && n < 12);
      chk_flag("handler_valid", 1'b1, handler_valid);
      chk_val("handler_addr", a ^ KEY, handler_addr);
      chk_flag("vec_fetch_req", 1'b0, vec_fetch_req);
    end
  endtask
  task do_reset;
    rst_b = 1'b0;
    repeat (12) tick();
    chk_flag("int_enable", 1'b1, int_enable);
    chk_val("cpu_priority_mask", 4'h0, cpu_priority_mask);
    rst_b = 1'b1;
    take(0, exc_pkg::RESET_VECTOR_ADDR, 1'b0);
    ie_m = 1;
    mask_m = 0;
    $display("test reset done");
  endtask

  // ==========================================================================
  // Main sequence: reset, random mixes of events, then reset again
  // ==========================================================================
  initial begin
    do_reset();
    for (i = 0; i < 90; i++) begin
      ie_m = (($random(seed) & 3) != 0);
      mask_m = $random(seed) & 15;
      ie_wr = 1'b1;
      ie_wdata = ie_m[0];
      mask_wr = 1'b1;
      mask_wdata = mask_m[3:0];
      tick();
      ie_wr = 1'b0;
      mask_wr = 1'b0;
      tick();
      chk_flag("int_enable", ie_m[0], int_enable);
      chk_val("cpu_priority_mask", mask_m, cpu_priority_mask);
      irq_level = 4'($random(seed));
      irq_vector = 8'($random(seed));
      trap_vector = 8'($random(seed));
      irq_fast = (($random(seed) & 7) == 0);
      irq_table_base = $random(seed);
      exc_table_base = $random(seed);
      fast_vector_addr = $random(seed);
      lag = 3'($random(seed));
      src = 8'((8'h01 << ($random(seed) & 7)) | ($random(seed) & $random(seed)));
      // Reference ranking, worked out from the event order and the mask.
      irq_ok = src[1] && ie_m != 0 && (irq_fast ? 15 : irq_level) > mask_m;
      if (src[0]) ev = 1;
      else if (irq_ok) ev = 2;
      else if (src[2]) ev = 3;
      else if (src[3] | src[4]) ev = 4;
      else if (src[5]) ev = 5;
      else if (src[6]) ev = 6;
      else if (src[7]) ev = 7;
      else ev = -1;
      case (ev)
        1: addr = slot(exc_table_base, exc_pkg::XV_NMI);
        2: addr = slot(irq_table_base, irq_vector);
        3: addr = slot(exc_table_base, exc_pkg::XV_IACC);
        4: addr = slot(exc_table_base, src[3] ? exc_pkg::XV_UNDEF : exc_pkg::XV_PRIV);
        5: addr = slot(irq_table_base, trap_vector);
        6: addr = slot(exc_table_base, exc_pkg::XV_OACC);
        default: addr = slot(exc_table_base, exc_pkg::XV_FPU);
      endcase
      if (ev < 0) begin
        repeat (4) begin
          tick();
          chk_flag("exc_taken", 1'b0, exc_taken);
        end
        src = 8'h00;
      end else begin
        take(ev, addr, ev == 2 && irq_fast);
      end
    end
    $display("test random done");
    do_reset();
    end_sim();
  end
endmodule
